// >>> logic/tmrgx_pkg.sv
// package: register map, field positions and reset values of the timer gate block
package tmrgx_pkg;
   // number of timer channels and request pins
   localparam int NUM_CH = 2;
   // register byte offsets on the bus
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_MASK = 8'h08;
   localparam logic [7:0] OFF_COUNT_A = 8'h0c;
   localparam logic [7:0] OFF_COUNT_B = 8'h10;
   localparam logic [7:0] OFF_PINS = 8'h14;
   // timer_control_reg fields, two bits each (bit 0 channel a, bit 1 channel b)
   localparam int CTRL_W = 8;
   localparam int CTRL_GATE_LSB = 0;
   localparam int CTRL_EDGE_LSB = 2;
   localparam int CTRL_RUN_LSB = 4;
   localparam int CTRL_CNTM_LSB = 6;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // status and mask layout
   localparam int ST_W = 4;
   localparam int ST_REQ_LSB = 0;
   localparam int ST_OVF_LSB = 2;
   localparam logic [3:0] ST_RST = 4'h0;
   localparam logic [3:0] MASK_RST = 4'h0;
   // pin readback layout
   localparam int PIN_REQ_LSB = 0;
   localparam int PIN_CNT_LSB = 2;
   // counters and synchroniser reset values
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic SYNC_RST = 1'b1;
endpackage : tmrgx_pkg

// >>> logic/tmrgx_pin_sync.sv
// module: two-stage pin synchroniser with falling-edge detector
module tmrgx_pin_sync #(
   parameter int WIDTH = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // raw pins
   input wire logic [WIDTH-1:0] pin_i,
   // synchronised level and one-cycle falling-edge pulse
   output logic [WIDTH-1:0] level_o,
   output logic [WIDTH-1:0] fall_o
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] prev_q;

   // reset to high so an idle pin gives no false edge after reset
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         meta_q <= {WIDTH{tmrgx_pkg::SYNC_RST}};
         sync_q <= {WIDTH{tmrgx_pkg::SYNC_RST}};
         prev_q <= {WIDTH{tmrgx_pkg::SYNC_RST}};
      end
      else
      begin
         meta_q <= pin_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // edge means a high sample followed by a low one
   assign level_o = sync_q;
   assign fall_o = prev_q & ~sync_q;
endmodule : tmrgx_pin_sync

// >>> logic/tmrgx_chan.sv
// module: one up-counting timer channel with load and wrap pulse
module tmrgx_chan #(
   parameter int CNT_W = 16
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // count step and software load
   input wire logic step_i,
   input wire logic load_i,
   input wire logic [CNT_W-1:0] load_val_i,
   // count value and wrap pulse
   output logic [CNT_W-1:0] count_o,
   output logic wrap_o
);
   logic [CNT_W-1:0] count_q;

   // a software load wins over a step in the same cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         count_q <= CNT_W'(tmrgx_pkg::COUNT_RST);
      else if (load_i)
         count_q <= load_val_i;
      else if (step_i)
         count_q <= count_q + CNT_W'(1);
   end

   assign count_o = count_q;
   // wrap from all ones to zero, lost when a load overrides it
   assign wrap_o = step_i & ~load_i & (&count_q);
endmodule : tmrgx_chan

// >>> logic/tmrgx_top.sv
// module: timer gate, request flag and counter input logic behind a wishbone slave
//
// Notes on behaviour
// - gate_select_a set: external_request_a high lets timer a count, low stops it.
// - gate_select_b set: external_request_b high lets timer b count, low stops it.
// - edge_mode_a set: falling edge on external_request_a sets request_flag_a.
// - edge_mode_a clear: low level sampled on external_request_a sets request_flag_a.
// - edge_mode_b set: falling edge on external_request_b sets request_flag_b.
// - edge_mode_b clear: low level sampled on external_request_b sets request_flag_b.
// - counter mode: timer a steps by one per falling edge on count_input_a.
// - counter mode: timer b steps by one per falling edge on count_input_b.
//
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
module tmrgx_top #(
   parameter int ADR_W = 8,
   parameter int CNT_W = 16
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // external pins
   input wire logic external_request_a_i,
   input wire logic external_request_b_i,
   input wire logic count_input_a_i,
   input wire logic count_input_b_i,
   // interrupt
   output logic irq_o
);
   localparam int NCH = tmrgx_pkg::NUM_CH;

   logic [NCH-1:0] req_lvl;
   logic [NCH-1:0] req_fall;
   logic [NCH-1:0] cnt_lvl;
   logic [NCH-1:0] cnt_fall;
   logic [tmrgx_pkg::CTRL_W-1:0] timer_control_reg_q;
   logic [tmrgx_pkg::ST_W-1:0] status_q;
   logic [tmrgx_pkg::ST_W-1:0] status_d;
   logic [tmrgx_pkg::ST_W-1:0] mask_q;
   logic [31:0] dat_q;
   logic [31:0] rd_data;
   logic ack_q;
   logic irq_q;
   logic [NCH-1:0] gate_sel;
   logic [NCH-1:0] edge_mode;
   logic [NCH-1:0] run_en;
   logic [NCH-1:0] cnt_mode;
   logic [NCH-1:0] req_set;
   logic [NCH-1:0] wrap;
   logic [NCH-1:0] load;
   logic [NCH-1:0] step;
   logic [CNT_W-1:0] count [NCH];
   logic [CNT_W-1:0] load_val [NCH];
   logic [CNT_W-1:0] count_inc [NCH];
   logic bus_req;
   logic wr_fire;
   logic [ADR_W-1:0] adr_off [NCH];

   // byte-lane merge of a write into the current value
   function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
            res[b*8 +: 8] = new_v[b*8 +: 8];
      end
      return res;
   endfunction : merge_sel

   // all four pins share one synchroniser bank
   tmrgx_pin_sync #(
      .WIDTH(2 * NCH)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i({count_input_b_i, count_input_a_i, external_request_b_i, external_request_a_i}),
      .level_o({cnt_lvl, req_lvl}),
      .fall_o({cnt_fall, req_fall})
   );

   // control fields
   assign gate_sel = timer_control_reg_q[tmrgx_pkg::CTRL_GATE_LSB +: NCH];
   assign edge_mode = timer_control_reg_q[tmrgx_pkg::CTRL_EDGE_LSB +: NCH];
   assign run_en = timer_control_reg_q[tmrgx_pkg::CTRL_RUN_LSB +: NCH];
   assign cnt_mode = timer_control_reg_q[tmrgx_pkg::CTRL_CNTM_LSB +: NCH];

   // bus strobes: write lands on the edge where the master sees ack
   assign bus_req = wb_cyc_i & wb_stb_i;
   assign wr_fire = bus_req & wb_we_i & ack_q;
   assign adr_off[0] = ADR_W'(tmrgx_pkg::OFF_COUNT_A);
   assign adr_off[1] = ADR_W'(tmrgx_pkg::OFF_COUNT_B);

   // per-channel gating, stepping and counter load
   for (genvar i = 0; i < NCH; i++)
   begin : g_ch
      // gate pin low stops counting only while gate select is set
      assign step[i] = run_en[i] & (~gate_sel[i] | req_lvl[i])
                       & (~cnt_mode[i] | cnt_fall[i]);
      // edge mode takes the pulse, level mode the low sample
      assign req_set[i] = edge_mode[i] ? req_fall[i] : ~req_lvl[i];
      assign load[i] = wr_fire & (wb_adr_i == adr_off[i]) & (|wb_sel_i[1:0]);
      assign load_val[i] = CNT_W'(merge_sel(32'(count[i]), wb_dat_i, wb_sel_i));
      assign count_inc[i] = count[i] + CNT_W'(1);

      tmrgx_chan #(
         .CNT_W(CNT_W)
      ) u_chan (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .step_i(step[i]),
         .load_i(load[i]),
         .load_val_i(load_val[i]),
         .count_o(count[i]),
         .wrap_o(wrap[i])
      );
   end

   // control register write
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         timer_control_reg_q <= tmrgx_pkg::CTRL_RST;
      else if (wr_fire && wb_adr_i == ADR_W'(tmrgx_pkg::OFF_CTRL) && wb_sel_i[0])
         timer_control_reg_q <= wb_dat_i[tmrgx_pkg::CTRL_W-1:0];
   end

   // mask register write
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         mask_q <= tmrgx_pkg::MASK_RST;
      else if (wr_fire && wb_adr_i == ADR_W'(tmrgx_pkg::OFF_MASK) && wb_sel_i[0])
         mask_q <= wb_dat_i[tmrgx_pkg::ST_W-1:0];
   end

   // sticky status: write one to clear, a new event wins over the clear
   always_comb
   begin
      status_d = status_q;
      if (wr_fire && wb_adr_i == ADR_W'(tmrgx_pkg::OFF_STATUS) && wb_sel_i[0])
         status_d = status_d & ~wb_dat_i[tmrgx_pkg::ST_W-1:0];
      status_d[tmrgx_pkg::ST_REQ_LSB +: NCH] = status_d[tmrgx_pkg::ST_REQ_LSB +: NCH]
                                               | req_set;
      status_d[tmrgx_pkg::ST_OVF_LSB +: NCH] = status_d[tmrgx_pkg::ST_OVF_LSB +: NCH] | wrap;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         status_q <= tmrgx_pkg::ST_RST;
      else
         status_q <= status_d;
   end

   // level interrupt, one cycle behind the status bits to keep the output flopped
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         irq_q <= 1'b0;
      else
         irq_q <= |(status_q & mask_q);
   end

   // read mux; unmapped offsets read as zero
   always_comb
   begin
      rd_data = 32'h0000_0000;
      unique case (wb_adr_i)
         ADR_W'(tmrgx_pkg::OFF_CTRL):
            rd_data[tmrgx_pkg::CTRL_W-1:0] = timer_control_reg_q;
         ADR_W'(tmrgx_pkg::OFF_STATUS):
            rd_data[tmrgx_pkg::ST_W-1:0] = status_q;
         ADR_W'(tmrgx_pkg::OFF_MASK):
            rd_data[tmrgx_pkg::ST_W-1:0] = mask_q;
         ADR_W'(tmrgx_pkg::OFF_COUNT_A):
            rd_data[CNT_W-1:0] = count[0];
         ADR_W'(tmrgx_pkg::OFF_COUNT_B):
            rd_data[CNT_W-1:0] = count[1];
         ADR_W'(tmrgx_pkg::OFF_PINS):
         begin
            rd_data[tmrgx_pkg::PIN_REQ_LSB +: NCH] = req_lvl;
            rd_data[tmrgx_pkg::PIN_CNT_LSB +: NCH] = cnt_lvl;
         end
         default:
            rd_data = 32'h0000_0000;
      endcase
   end

   // ack one cycle after the request, dropped in the cycle after it
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ack_q <= 1'b0;
      else
         ack_q <= bus_req & ~ack_q;
   end

   // read data captured with the request; a counter read shows the value one cycle old
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         dat_q <= 32'h0000_0000;
      else if (bus_req && !ack_q && !wb_we_i)
         dat_q <= rd_data;
   end

   assign wb_dat_o = dat_q;
   assign wb_ack_o = ack_q;
   assign irq_o = irq_q;

   // checks
   sequence s_pin_a_fall;
      external_request_a_i ##1 !external_request_a_i;
   endsequence

   a_gate_stops_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (gate_sel[0] && !req_lvl[0] && !load[0]) |=> $stable(count[0]))
      else $error("timer a moved while its gate pin was low");

   a_gate_stops_b: assert property (@(posedge clk_i) disable iff (rst_i)
      (gate_sel[1] && !req_lvl[1] && !load[1]) |=> $stable(count[1]))
      else $error("timer b moved while its gate pin was low");

   a_edge_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (edge_mode[0] && req_fall[0]) |=> status_q[tmrgx_pkg::ST_REQ_LSB])
      else $error("falling edge did not set request flag a");

   a_level_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!edge_mode[0] && !req_lvl[0]) |=> status_q[tmrgx_pkg::ST_REQ_LSB])
      else $error("low level did not set request flag a");

   a_edge_flag_b: assert property (@(posedge clk_i) disable iff (rst_i)
      (edge_mode[1] && req_fall[1]) |=> status_q[tmrgx_pkg::ST_REQ_LSB + 1])
      else $error("falling edge did not set request flag b");

   a_level_flag_b: assert property (@(posedge clk_i) disable iff (rst_i)
      (!edge_mode[1] && !req_lvl[1]) |=> status_q[tmrgx_pkg::ST_REQ_LSB + 1])
      else $error("low level did not set request flag b");

   a_count_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cnt_mode[0] && run_en[0] && !gate_sel[0] && !load[0])
      |=> (count[0] == ($past(cnt_fall[0]) ? $past(count_inc[0]) : $past(count[0]))))
      else $error("timer a count did not follow count pin edges");

   a_count_step_b: assert property (@(posedge clk_i) disable iff (rst_i)
      (cnt_mode[1] && run_en[1] && !gate_sel[1] && !load[1])
      |=> (count[1] == ($past(cnt_fall[1]) ? $past(count_inc[1]) : $past(count[1]))))
      else $error("timer b count did not follow count pin edges");

   a_sync_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_pin_a_fall |-> ##2 req_fall[0])
      else $error("pin a falling edge not seen two cycles later");

   // the other three pins go through the same bank, so each gets the same latency check
   sequence s_pin_b_fall;
      external_request_b_i ##1 !external_request_b_i;
   endsequence

   sequence s_cnt_a_fall;
      count_input_a_i ##1 !count_input_a_i;
   endsequence

   sequence s_cnt_b_fall;
      count_input_b_i ##1 !count_input_b_i;
   endsequence

   a_sync_edge_b: assert property (@(posedge clk_i) disable iff (rst_i)
      s_pin_b_fall |-> ##2 req_fall[1])
      else $error("pin b falling edge not seen two cycles later");

   a_sync_cnt_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_cnt_a_fall |-> ##2 cnt_fall[0])
      else $error("count pin a falling edge not seen two cycles later");

   a_sync_cnt_b: assert property (@(posedge clk_i) disable iff (rst_i)
      s_cnt_b_fall |-> ##2 cnt_fall[1])
      else $error("count pin b falling edge not seen two cycles later");

   // a second ack would make a classic master take one request twice
   a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack stood for more than one cycle");

   // interrupt follows the unmasked status bits one cycle late
   a_irq_raise: assert property (@(posedge clk_i) disable iff (rst_i)
      ((status_q & mask_q) != '0) |=> irq_o)
      else $error("irq low although an unmasked status bit was set");

   a_irq_drop: assert property (@(posedge clk_i) disable iff (rst_i)
      ((status_q & mask_q) == '0) |=> !irq_o)
      else $error("irq high with no unmasked status bit set");

   // a wrap that is not cancelled by a load must leave its overflow flag set
   a_wrap_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wrap[0] |=> status_q[tmrgx_pkg::ST_OVF_LSB])
      else $error("timer a wrapped without setting its overflow flag");

   a_wrap_flag_b: assert property (@(posedge clk_i) disable iff (rst_i)
      wrap[1] |=> status_q[tmrgx_pkg::ST_OVF_LSB + 1])
      else $error("timer b wrapped without setting its overflow flag");
endmodule : tmrgx_top

// >>> tb/tmrgx_pin_src.sv
// pin source model: drives request and count pins, idle high as with pull-ups
module tmrgx_pin_src (
   // clock
   input wire logic clk_i,
   // pins: 0 request a, 1 request b, 2 count a, 3 count b
   output logic [3:0] pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // pulled-up pins rest high, so reset sees no edge
   initial pin_o = 4'hf;
   // set one pin level just after a rising edge
   task automatic hold(input int idx, input logic v);
      @(posedge clk_i);
      pin_o[idx] <= v;
   endtask : hold
   // one-cycle low pulse; back high so the next fall is a distinct edge
   task automatic fall(input int idx);
      hold(idx, 1'b0);
      hold(idx, 1'b1);
   endtask : fall
endmodule : tmrgx_pin_src

// >>> tb/testbench.sv
// testbench: register, request flag, gate and counter checks of the timer gate block
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
   $display("CHECK FAILED %0t got %h exp %h", $time, (a), (b)); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [31:0] wb_wd = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic irq_o;
   logic [3:0] pins;
   logic [31:0] q;
   int error_cnt = 0;
   int checks_done = 0;
   int cyc_cnt = 0;
   // 4 ns clock
   initial
   begin
      forever #2 clk_i = ~clk_i;
   end
   tmrgx_pin_src u_src (.clk_i(clk_i), .pin_o(pins));
   tmrgx_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wd),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .external_request_a_i(pins[0]),
      .external_request_b_i(pins[1]), .count_input_a_i(pins[2]),
      .count_input_b_i(pins[3]), .irq_o(irq_o));
   // verdict and end of run
   task automatic results();
      if (error_cnt == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : results
   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge clk_i)
   begin
      cyc_cnt++;
      if (cyc_cnt == 5000)
      begin
         error_cnt++;
         results();
      end
   end
   // one classic cycle; held until ack is sampled, data taken at that edge
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_wd <= d;
      @(posedge clk_i);
      // no wait limit of its own: a lost answer is ended by the hang guard
      while (wb_ack_o !== 1'b1)
      begin
         @(posedge clk_i);
      end
      q = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
      wb(1'b0, adr, 32'h0);
      `CHK(q, exp)
   endtask : rdchk
   // two back-to-back reads are taken 3 edges apart
   task automatic rate(input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] q1;
      wb(1'b0, adr, 32'h0);
      q1 = q;
      wb(1'b0, adr, 32'h0);
      `CHK(q - q1, exp)
   endtask : rate
   // reset values, pin readback, unmapped place
   task automatic t_reset();
      rdchk(8'h00, 32'h0);
      rdchk(8'h04, 32'h0);
      rdchk(8'h08, 32'h0);
      rdchk(8'h0c, 32'h0);
      rdchk(8'h14, 32'h0000000f);
      wb(1'b1, 8'h18, 32'hffffffff);
      rdchk(8'h18, 32'h0);
   endtask : t_reset
   // edge mode: a one-cycle low sets only its own flag; mask gates irq
   task automatic t_edge();
      wb(1'b1, 8'h00, 32'h0c);
      wb(1'b1, 8'h08, 32'h3);
      for (int ch = 0; ch < 2; ch++)
      begin
         u_src.fall(ch);
         repeat (6) @(posedge clk_i);
         rdchk(8'h04, 32'h1 << ch);
         `CHK(irq_o, 1'b1)
         wb(1'b1, 8'h04, 32'h1 << ch);
         rdchk(8'h04, 32'h0);
         `CHK(irq_o, 1'b0)
      end
      wb(1'b1, 8'h08, 32'h0);
      u_src.fall(1);
      repeat (6) @(posedge clk_i);
      rdchk(8'h04, 32'h2);
      `CHK(irq_o, 1'b0)
      wb(1'b1, 8'h04, 32'h2);
   endtask : t_edge
   // level mode: flag re-sets while the pin is low, a write-one clear holds once it is high
   task automatic t_level();
      wb(1'b1, 8'h00, 32'h0);
      u_src.hold(0, 1'b0);
      u_src.hold(1, 1'b0);
      repeat (4) @(posedge clk_i);
      wb(1'b1, 8'h04, 32'h3);
      rdchk(8'h04, 32'h3);
      u_src.hold(0, 1'b1);
      u_src.hold(1, 1'b1);
      repeat (4) @(posedge clk_i);
      wb(1'b1, 8'h04, 32'h3);
      rdchk(8'h04, 32'h0);
   endtask : t_level
   // gate: request pin low halts its timer only while gate select is set
   task automatic t_gate();
      for (int ch = 0; ch < 2; ch++)
      begin
         wb(1'b1, 8'h00, 32'h33);
         u_src.hold(ch, 1'b0);
         repeat (4) @(posedge clk_i);
         rate(8'h0c + 8'(ch * 4), 32'h0);
         u_src.hold(ch, 1'b1);
         repeat (4) @(posedge clk_i);
         rate(8'h0c + 8'(ch * 4), 32'h3);
         u_src.hold(ch, 1'b0);
         wb(1'b1, 8'h00, 32'h30);
         rate(8'h0c + 8'(ch * 4), 32'h3);
         u_src.hold(ch, 1'b1);
      end
   endtask : t_gate
   // counter mode: three single-cycle falls step each timer by three
   task automatic t_count();
      wb(1'b1, 8'h00, 32'hfc);
      wb(1'b1, 8'h0c, 32'h0);
      wb(1'b1, 8'h10, 32'h0);
      for (int i = 0; i < 3; i++)
      begin
         u_src.fall(2);
         u_src.fall(3);
      end
      repeat (6) @(posedge clk_i);
      rdchk(8'h0c, 32'h3);
      rdchk(8'h10, 32'h3);
      // wrap: a fall at all ones gives zero and sets only overflow a
      wb(1'b1, 8'h04, 32'hf);
      wb(1'b1, 8'h0c, 32'hffff);
      u_src.fall(2);
      repeat (6) @(posedge clk_i);
      rdchk(8'h0c, 32'h0);
      rdchk(8'h04, 32'h4);
   endtask : t_count
   // main sequence
   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_edge();
      t_level();
      t_gate();
      t_count();
      results();
   end
endmodule : testbench
